// ---- common/call_clear_pkg.sv ----
// shared types and constants for the call / clear / watchdog execution slice
// assumes a 14-bit program counter and byte-wide data memory
package call_clear_pkg;
	localparam int PC_W   = 14;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int BIT_W  = 3;
	localparam logic [PC_W-1:0]   PC_STEP    = 14'h0001;
	localparam logic [PC_W-1:0]   PC_RESET   = 14'h0000;
	localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
	localparam logic [DATA_W-1:0] BIT_ONE    = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_ZERO  = 10'h000;

	typedef enum logic [2:0] {
		OP_NONE       = 3'b000,
		OP_CALL       = 3'b001,
		OP_ZERO_BYTE  = 3'b010,
		OP_ZERO_BIT   = 3'b011,
		OP_WDT_RESET  = 3'b100,
		OP_WDT_FIRST  = 3'b101,
		OP_WDT_SECOND = 3'b110
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LOAD   = 2'b01
	} exec_state_t;

	typedef struct packed {
		op_t               op;
		logic [PC_W-1:0]   target;
		logic [ADDR_W-1:0] memAddr;
		logic [BIT_W-1:0]  bitSel;
	} instr_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_wr_t;
endpackage

// ---- dv/tb.sv ----
// self-checking bench for the call / clear / watchdog execution slice
// assumes call_clear_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module tb;
	import call_clear_pkg::*;
	logic                  sys_clk = 0, rst_b = 0, instrValid = 0;
	logic                  timeoutSet = 0, powerdownSet = 0, busy, stackPush;
	logic                  watchdogClear, timeout_flag, powerdown_flag;
	instr_t                instr = '0;
	logic [DATA_W-1:0]     memRdData = '0;
	logic [PC_W-1:0]       pc, stackData, expPc;
	logic [ADDR_W-1:0]     memRdAddr;
	mem_wr_t               memWr;
	int                    errorCnt = 0, testsRun = 0;

	call_clear_exec i_call_clear_exec (.sys_clk(sys_clk), .rst_b(rst_b),
		.instrValid(instrValid), .instr(instr), .memRdData(memRdData),
		.timeoutSet(timeoutSet), .powerdownSet(powerdownSet), .busy(busy), .pc(pc),
		.stackPush(stackPush), .stackData(stackData), .memRdAddr(memRdAddr),
		.memWr(memWr), .watchdogClear(watchdogClear), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag));

	always #12.5 sys_clk = ~sys_clk;

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one accepted op; returns at the falling edge after the taking edge
	task automatic issue(op_t op, logic [PC_W-1:0] tg, logic [ADDR_W-1:0] a,
			logic [BIT_W-1:0] b, logic [DATA_W-1:0] rd);
		instr = '{op, tg, a, b};
		memRdData = rd;
		instrValid = 1;
		#2;
		check("memRdAddr", memRdAddr, a);
		@(negedge sys_clk);
		instrValid = 0;
		expPc = expPc + PC_STEP;
	endtask

	task automatic set_flags();
		timeoutSet = 1;
		powerdownSet = 1;
		@(negedge sys_clk);
		timeoutSet = 0;
		powerdownSet = 0;
		@(negedge sys_clk);
	endtask

	task automatic test_call();
		logic [PC_W-1:0] ret;
		ret = expPc + PC_STEP;
		issue(OP_CALL, 14'h2A5C, ADDR_ZERO, 3'h0, BYTE_ZERO);
		check("stackPush", stackPush, 1);
		check("stackData", stackData, ret);
		check("busy", busy, 1);
		// a request while busy must be ignored
		instr.op = OP_WDT_RESET;
		instrValid = 1;
		@(negedge sys_clk);
		instrValid = 0;
		check("pc", pc, 14'h2A5C);
		check("busy", busy, 0);
		check("stackPush", stackPush, 0);
		check("watchdogClear", watchdogClear, 0);
		expPc = 14'h2A5C;
		$display("call test done");
	endtask

	task automatic test_clear_byte();
		set_flags();
		issue(OP_ZERO_BYTE, 14'h0000, 10'h3A5, 3'h0, 8'hFF);
		check("we", memWr.we, 1);
		check("addr", memWr.addr, 10'h3A5);
		check("data", memWr.data, BYTE_ZERO);
		check("timeout", timeout_flag, 1);
		check("pc", pc, expPc);
		$display("clear byte test done");
	endtask

	task automatic test_clear_bit();
		logic [DATA_W-1:0] expByte;
		for (int b = 0; b < DATA_W; b++) begin
			// selected bit is always one beforehand, so the clear is visible
			expByte = 8'hFF ^ 8'(b);
			expByte[b] = 1'b0;
			issue(OP_ZERO_BIT, 14'h0000, 10'h155 + 10'(b), 3'(b), 8'hFF ^ 8'(b));
			check("data", memWr.data, expByte);
			check("addr", memWr.addr, 10'h155 + 10'(b));
			check("we", memWr.we, 1);
			check("powerdown", powerdown_flag, 1);
		end
		$display("clear bit test done");
	endtask

	task automatic pre(op_t op, logic expClr);
		issue(op, 14'h0000, ADDR_ZERO, 3'h0, BYTE_ZERO);
		check("watchdogClear", watchdogClear, expClr);
		check("timeout", timeout_flag, !expClr);
		check("powerdown", powerdown_flag, !expClr);
		if (expClr)
			set_flags();
	endtask

	task automatic test_watchdog();
		issue(OP_WDT_RESET, 14'h0000, ADDR_ZERO, 3'h0, BYTE_ZERO);
		check("watchdogClear", watchdogClear, 1);
		check("timeout", timeout_flag, 0);
		check("powerdown", powerdown_flag, 0);
		set_flags();
		// first pre-clear since reset, a repeat, an alternation, a repeat, a no-op, then an alternation
		pre(OP_WDT_FIRST, 0);
		pre(OP_WDT_FIRST, 0);
		pre(OP_WDT_SECOND, 1);
		pre(OP_WDT_SECOND, 0);
		pre(OP_NONE, 0);
		pre(OP_WDT_FIRST, 1);
		check("pc", pc, expPc);
		$display("watchdog test done");
	endtask

	initial begin
		expPc = PC_RESET;
		fork
			begin
				#(25 * 2000);
				errorCnt++;
				giveVerdict();
			end
		join_none
		repeat (8) @(negedge sys_clk);
		check("pc", pc, PC_RESET);
		rst_b = 1;
		test_call();
		test_clear_byte();
		test_clear_bit();
		test_watchdog();
		giveVerdict();
	end
endmodule

// ---- hw/call_clear_exec.sv ----
// executes call, clear-byte, clear-bit and the three watchdog clear commands
// assumes decode presents one instruction per cycle with instrValid, and that
// decode stalls while busy is high; stack, memory and watchdog sit outside
//
// Operation
// RULE_01 - a call pushes the current address plus one, then loads the target into the PC.
// RULE_02 - a call occupies two instruction cycles, the second loading the new address.
// RULE_03 - clear-byte writes zero to the whole addressed byte and leaves status flags alone.
// RULE_04 - clear-bit zeroes only the selected bit, keeping other bits and the flags.
// RULE_05 - the watchdog reset command clears the counter, timeout flag and power-down flag.
// RULE_06 - the first pre-clear acts only when it alternates with the second pre-clear.
// RULE_07 - the second pre-clear acts only when it alternates with the first pre-clear.
// RULE_08 - a one-bit record remembers which pre-clear executed last.
`timescale 1ns/1ps
module call_clear_exec (
	input  wire logic                        sys_clk,
	input  wire logic                        rst_b,
	input  wire logic                        instrValid,
	input  wire call_clear_pkg::instr_t      instr,
	input  wire logic [call_clear_pkg::DATA_W-1:0] memRdData,
	input  wire logic                        timeoutSet,
	input  wire logic                        powerdownSet,
	output logic                             busy,
	output logic [call_clear_pkg::PC_W-1:0]  pc,
	output logic                             stackPush,
	output logic [call_clear_pkg::PC_W-1:0]  stackData,
	output logic [call_clear_pkg::ADDR_W-1:0] memRdAddr,
	output call_clear_pkg::mem_wr_t          memWr,
	output logic                             watchdogClear,
	output logic                             timeout_flag,
	output logic                             powerdown_flag
);
	import call_clear_pkg::*;

	function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] sel);
		bit_mask = BIT_ONE << sel;
	endfunction

	exec_state_t       state;
	exec_state_t       next_state;
	logic [PC_W-1:0]   target;
	logic [PC_W-1:0]   next_target;
	logic [PC_W-1:0]   next_pc;
	logic              next_stackPush;
	logic [PC_W-1:0]   next_stackData;
	mem_wr_t           next_memWr;
	logic              next_watchdogClear;
	logic              next_timeout;
	logic              next_powerdown;
	logic              accept;
	logic              firstCmd;
	logic              secondCmd;
	logic              preclearHit;
	logic              wdtHit;

	assign busy      = (state == ST_LOAD);
	assign accept    = instrValid & ~busy;
	assign firstCmd  = accept & (instr.op == OP_WDT_FIRST);
	assign secondCmd = accept & (instr.op == OP_WDT_SECOND);
	// clear-bit reads the byte in the same cycle; memory read is combinational
	assign memRdAddr = accept ? instr.memAddr : ADDR_ZERO;

	preclear_tracker u_tracker (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.firstCmd  (firstCmd),
		.secondCmd (secondCmd),
		.clearNow  (preclearHit)
	);

	// RULE_05 single-step watchdog clear
	assign wdtHit = (accept & (instr.op == OP_WDT_RESET)) | preclearHit;

	always_comb begin
		next_state         = state;
		next_target        = target;
		next_pc            = pc;
		next_stackPush     = 1'b0;
		next_stackData     = stackData;
		next_memWr         = '{we: 1'b0, addr: memWr.addr, data: memWr.data};
		next_watchdogClear = wdtHit;
		// an external set in the same cycle as a clear wins, so a real timeout
		// or power-down event is never lost to a clear command racing it
		next_timeout       = timeoutSet ? 1'b1 : (wdtHit ? 1'b0 : timeout_flag);
		next_powerdown     = powerdownSet ? 1'b1 : (wdtHit ? 1'b0 : powerdown_flag);
		unique case (state)
			ST_IDLE: begin
				if (accept) begin
					next_pc = pc + PC_STEP;
					unique case (instr.op)
						OP_CALL: begin
							// RULE_01 push return address
							next_stackPush = 1'b1;
							next_stackData = pc + PC_STEP;
							next_target    = instr.target;
							next_state     = ST_LOAD;
						end
						OP_ZERO_BYTE: begin
							// RULE_03 whole byte zero
							next_memWr = '{we: 1'b1, addr: instr.memAddr, data: BYTE_ZERO};
						end
						OP_ZERO_BIT: begin
							// RULE_04 single bit zero
							next_memWr = '{we: 1'b1, addr: instr.memAddr,
								data: memRdData & ~bit_mask(instr.bitSel)};
						end
						OP_NONE, OP_WDT_RESET, OP_WDT_FIRST, OP_WDT_SECOND: begin
						end
						default: begin
						end
					endcase
				end
			end
			ST_LOAD: begin
				// RULE_02 second cycle loads target
				next_pc    = target;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state          <= ST_IDLE;
			target         <= PC_RESET;
			pc             <= PC_RESET;
			stackPush      <= 1'b0;
			stackData      <= PC_RESET;
			memWr          <= '0;
			watchdogClear  <= 1'b0;
			timeout_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
		end else begin
			state          <= next_state;
			target         <= next_target;
			pc             <= next_pc;
			stackPush      <= next_stackPush;
			stackData      <= next_stackData;
			memWr          <= next_memWr;
			watchdogClear  <= next_watchdogClear;
			timeout_flag   <= next_timeout;
			powerdown_flag <= next_powerdown;
		end
	end

	sequence s_call_taken;
		accept && instr.op == OP_CALL;
	endsequence
	sequence s_load_done;
		##2 (pc == $past(instr.target, 2));
	endsequence

	a_call_push: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_01
		s_call_taken |=> stackPush && stackData == $past(pc) + PC_STEP)
		else $error("call did not push pc plus one");
	a_call_two: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_02
		s_call_taken |=> busy ##1 !busy)
		else $error("call not two cycles");
	a_call_target: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_01
		s_call_taken |-> s_load_done)
		else $error("call target not loaded");
	a_byte_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_03
		accept && instr.op == OP_ZERO_BYTE |=>
		memWr.we && memWr.data == BYTE_ZERO && memWr.addr == $past(instr.memAddr))
		else $error("clear byte wrong");
	a_bit_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_04
		accept && instr.op == OP_ZERO_BIT |=> memWr.we &&
		memWr.data == ($past(memRdData) & ~bit_mask($past(instr.bitSel))))
		else $error("clear bit wrong");
	a_flags_keep: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_03
		accept && (instr.op == OP_ZERO_BYTE || instr.op == OP_ZERO_BIT)
		&& !timeoutSet && !powerdownSet |=> timeout_flag == $past(timeout_flag)
		&& powerdown_flag == $past(powerdown_flag))
		else $error("clear changed status flag");
	a_wdt_reset: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_05
		accept && instr.op == OP_WDT_RESET && !timeoutSet && !powerdownSet |=>
		watchdogClear && !timeout_flag && !powerdown_flag)
		else $error("watchdog reset incomplete");
	a_preclear_fx: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_06
		preclearHit && !timeoutSet && !powerdownSet |=>
		watchdogClear && !timeout_flag && !powerdown_flag)
		else $error("pre-clear pair had no effect");
	a_no_spurious: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_07
		!wdtHit |=> !watchdogClear)
		else $error("watchdog clear without cause");
endmodule

// ---- hw/preclear_tracker.sv ----
// records which pre-clear command executed last and flags a valid alternation
// assumes first/second pulses are one cycle and mutually exclusive
`timescale 1ns/1ps
module preclear_tracker (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic firstCmd,
	input  wire logic secondCmd,
	output logic      clearNow
);
	import call_clear_pkg::*;

	// lastSecond high means the second pre-clear ran last; seen says any ran yet
	logic lastSecond;
	logic seen;
	logic next_lastSecond;
	logic next_seen;

	// RULE_08 one-bit last record
	always_comb begin
		next_lastSecond = lastSecond;
		next_seen       = seen;
		if (firstCmd) begin
			next_lastSecond = 1'b0;
			next_seen       = 1'b1;
		end else if (secondCmd) begin
			next_lastSecond = 1'b1;
			next_seen       = 1'b1;
		end
	end

	// RULE_06 RULE_07 alternation only
	// the very first pre-clear after reset has no partner, so it does nothing
	assign clearNow = seen & ((firstCmd & lastSecond) | (secondCmd & ~lastSecond));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lastSecond <= 1'b0;
			seen       <= 1'b0;
		end else begin
			lastSecond <= next_lastSecond;
			seen       <= next_seen;
		end
	end

	sequence s_first_then_second;
		firstCmd ##1 secondCmd;
	endsequence

	a_repeat_first: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_06
		firstCmd && !lastSecond |-> !clearNow)
		else $error("repeated first pre-clear took effect");
	a_repeat_second: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_07
		secondCmd && lastSecond |-> !clearNow)
		else $error("repeated second pre-clear took effect");
	a_alternate_ok: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_08
		s_first_then_second |-> clearNow)
		else $error("alternation not recognised");
	a_record_first: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_08
		firstCmd |=> seen && !lastSecond)
		else $error("first pre-clear not recorded");
	a_record_second: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_08
		secondCmd |=> seen && lastSecond)
		else $error("second pre-clear not recorded");
endmodule
